// ---- design/dgc_grouping_reg.sv ----
`timescale 1ns/1ps
module dgc_grouping_reg (
  // Core clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Serial register port
  input wire logic serial_clk,
  input wire logic chip_select_n,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  // Actuation sequencer
  input wire logic output_enable_pin,
  input wire logic timed_actuation_active,
  input wire logic indefinite_braking_active,
  input wire logic [1:0] braking_duration_sel,
  input wire logic reg01_write_strobe,
  // Bridge commands and regulation settings
  input wire logic [5:0][1:0] bridge_cmd,
  input wire dgc_pkg::dgc_bridge_set_t [5:0] bridge_setting,
  // Protection and status
  input wire logic [5:0] thermal_shutdown,
  input wire logic global_fault_summary_bit,
  // Effective configuration and derived controls
  output dgc_pkg::dgc_cfg_t active_cfg,
  output logic [5:0][1:0] bridge_drive,
  output logic [5:0] bridge_pwm_mode,
  output logic [5:0][3:0] bridge_level,
  output logic [1:0][5:0] group_current_sum,
  output logic pump_dither_run,
  output dgc_pkg::dgc_shutdown_t shutdown,
  // Fault pin
  output logic fault_pin_out,
  output logic fault_pin_oe
);

  // Link domain: shift in on rising edge, shift out on falling edge
  logic frame_fresh;
  logic [4:0] bit_cnt;
  logic [23:0] shift_in;
  logic addr_hit;
  dgc_pkg::dgc_cfg_t programmed_cfg;

  // Restart flag set by chip select high; no edge after the frame is needed
  always_ff @(posedge serial_clk or posedge chip_select_n) begin
    if (chip_select_n) begin
      frame_fresh <= 1'b1;
    end else begin
      frame_fresh <= 1'b0;
    end
  end

  // Serial clock is idle during core reset, so release is safe
  wire [4:0] next_bit_cnt = frame_fresh ? 5'h01 :
                            (bit_cnt == dgc_pkg::FRAME_OVERRUN) ? bit_cnt : bit_cnt + 5'h01;

  // Address captured once complete; the shifter keeps moving under the data bits
  wire addr_now = ({shift_in[4:0], serial_data_in} == dgc_pkg::ADDR_GROUPING);

  always_ff @(posedge serial_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bit_cnt <= 5'h00;
      shift_in <= 24'h000000;
      addr_hit <= 1'b0;
    end else begin
      bit_cnt <= next_bit_cnt;
      shift_in <= {shift_in[22:0], serial_data_in};
      if (next_bit_cnt == 5'h08) begin
        addr_hit <= addr_now;
      end
    end
  end

  // Stored value changes only just after chip select rises, never mid-frame
  wire reply_parity = ~^programmed_cfg;
  wire [15:0] reply_data = addr_hit ?
                           {dgc_pkg::RESERVED_READ, programmed_cfg, reply_parity} : 16'h0000;
  wire [23:0] reply_word = {dgc_pkg::STATUS_READ, reply_data};
  wire [4:0] reply_index = 5'h17 - bit_cnt;

  always_ff @(negedge serial_clk or posedge chip_select_n) begin
    if (chip_select_n) begin
      serial_data_out <= 1'b0;
    end else if (bit_cnt < dgc_pkg::FRAME_LEN) begin
      serial_data_out <= reply_word[reply_index];
    end else begin
      serial_data_out <= 1'b0;
    end
  end

  // Core domain synchronisers
  logic csn_meta;
  logic csn_sync;
  logic csn_prev;
  logic en_meta;
  logic en_sync;
  logic en_prev;
  logic timed_prev;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      csn_meta <= 1'b1;
      csn_sync <= 1'b1;
      csn_prev <= 1'b1;
      en_meta <= 1'b0;
      en_sync <= 1'b0;
      en_prev <= 1'b0;
      timed_prev <= 1'b0;
    end else begin
      csn_meta <= chip_select_n;
      csn_sync <= csn_meta;
      csn_prev <= csn_sync;
      en_meta <= output_enable_pin;
      en_sync <= en_meta;
      en_prev <= en_sync;
      timed_prev <= timed_actuation_active;
    end
  end

  wire cs_rise = csn_sync & ~csn_prev;
  wire en_rise = en_sync & ~en_prev;
  wire timed_end = timed_prev & ~timed_actuation_active;

  // Frame words are stable once chip select is high, read as a handshake
  dgc_pkg::dgc_frame_t rx_frame;
  assign rx_frame = shift_in;
  wire frame_good = (bit_cnt == dgc_pkg::FRAME_LEN) & (^shift_in);
  wire write_event = cs_rise & frame_good & (rx_frame.op == dgc_pkg::OP_WRITE) &
                     (rx_frame.addr == dgc_pkg::ADDR_GROUPING);
  // Reserved bits 15..8 are dropped here
  wire [6:0] rx_cfg = rx_frame.data[dgc_pkg::FLD_CFG_MSB:dgc_pkg::FLD_CFG_LSB];

  // Indefinite braking, or a timed run that ends in it
  wire indef_busy = indefinite_braking_active |
                    (timed_actuation_active &
                     (braking_duration_sel == dgc_pkg::BRAKE_INDEFINITE));

  dgc_pkg::dgc_apply_t apply_state;
  dgc_pkg::dgc_apply_t next_apply_state;
  dgc_pkg::dgc_cfg_t next_programmed_cfg;
  dgc_pkg::dgc_cfg_t next_active_cfg;

  assign next_programmed_cfg = write_event ? rx_cfg : programmed_cfg;

  always_comb begin
    next_apply_state = apply_state;
    next_active_cfg = active_cfg;
    case (apply_state)
      dgc_pkg::APPLY_IDLE: begin
        if (write_event) begin
          if (indef_busy) begin
            next_apply_state = dgc_pkg::APPLY_WAIT_INDEF;
          end else if (timed_actuation_active) begin
            next_apply_state = dgc_pkg::APPLY_WAIT_TIMED;
          end else begin
            next_active_cfg = next_programmed_cfg;
          end
        end
      end
      dgc_pkg::APPLY_WAIT_TIMED: begin
        if (timed_end) begin
          if (indefinite_braking_active) begin
            next_apply_state = dgc_pkg::APPLY_WAIT_INDEF;
          end else begin
            next_apply_state = dgc_pkg::APPLY_IDLE;
            next_active_cfg = next_programmed_cfg;
          end
        end
      end
      dgc_pkg::APPLY_WAIT_INDEF: begin
        if (reg01_write_strobe | en_rise) begin
          next_apply_state = dgc_pkg::APPLY_IDLE;
          next_active_cfg = next_programmed_cfg;
        end
      end
      default: begin
        next_apply_state = dgc_pkg::APPLY_IDLE;
      end
    endcase
  end

  // Only reset clears the registers; thermal events never touch them
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      apply_state <= dgc_pkg::APPLY_IDLE;
      programmed_cfg <= dgc_pkg::CFG_RESET;
      active_cfg <= dgc_pkg::CFG_RESET;
    end else begin
      apply_state <= next_apply_state;
      programmed_cfg <= next_programmed_cfg;
      active_cfg <= next_active_cfg;
    end
  end

  // Group membership: index 0 is group 1 (outputs 1-3), 1 is group 2
  wire [1:0][1:0] grp_add = {{active_cfg.second_group_add_out6, active_cfg.second_group_add_out5},
                             {active_cfg.first_group_add_out3, active_cfg.first_group_add_out2}};
  wire any_thermal = |thermal_shutdown;
  wire global_scope = active_cfg.thermal_scope_select;
  logic [5:0] in_group;
  logic [1:0][5:0] next_group_sum;

  genvar k;
  generate
    for (k = 0; k < 2; k = k + 1) begin : g_group
      // Members' codes add up at the master output
      assign next_group_sum[k] = {2'h0, bridge_setting[3*k].level_setting_field} +
        (grp_add[k][0] ? {2'h0, bridge_setting[3*k+1].level_setting_field} : 6'h00) +
        (grp_add[k][1] ? {2'h0, bridge_setting[3*k+2].level_setting_field} : 6'h00);

      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          group_current_sum[k] <= 6'h00;
        end else if (in_group[3*k]) begin
          group_current_sum[k] <= next_group_sum[k];
        end else begin
          group_current_sum[k] <= {2'h0, bridge_setting[3*k].level_setting_field};
        end
      end
    end
  endgenerate

  genvar i;
  generate
    for (i = 0; i < 6; i = i + 1) begin : g_bridge
      localparam int GRP = i / 3;
      localparam int POS = i % 3;
      localparam int MASTER = GRP * 3;
      // Master belongs when any other member is added
      if (POS == 0) begin : g_master
        assign in_group[i] = |grp_add[GRP];
      end else begin : g_member
        assign in_group[i] = grp_add[GRP][POS-1];
      end

      // Mode is taken from the master; host keeps members equal
      wire master_pwm = bridge_setting[MASTER].regulation_mode_select;
      wire [1:0] next_drive = in_group[i] ? bridge_cmd[MASTER] : bridge_cmd[i];
      wire next_pwm = in_group[i] ? master_pwm : bridge_setting[i].regulation_mode_select;
      wire [3:0] next_level = (in_group[i] & master_pwm) ?
                              bridge_setting[MASTER].level_setting_field :
                              bridge_setting[i].level_setting_field;

      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          bridge_drive[i] <= 2'h0;
          bridge_pwm_mode[i] <= 1'b0;
          bridge_level[i] <= 4'h0;
          shutdown.internal_bridge_output[i] <= 1'b0;
        end else begin
          bridge_drive[i] <= next_drive;
          bridge_pwm_mode[i] <= next_pwm;
          bridge_level[i] <= next_level;
          shutdown.internal_bridge_output[i] <= global_scope ? any_thermal :
                                                thermal_shutdown[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      shutdown.external_bridge_output <= 2'h0;
      shutdown.charge_pump <= 1'b0;
      pump_dither_run <= 1'b0;
      fault_pin_out <= 1'b1;
      fault_pin_oe <= 1'b0;
      serial_data_oe <= 1'b0;
    end else begin
      shutdown.external_bridge_output <= {2{global_scope & any_thermal}};
      shutdown.charge_pump <= global_scope & any_thermal;
      pump_dither_run <= ~active_cfg.pump_dither_disable;
      fault_pin_out <= ~global_fault_summary_bit;
      fault_pin_oe <= active_cfg.global_fault_pin_enable;
      serial_data_oe <= ~csn_sync;
    end
  end

endmodule : dgc_grouping_reg

// ---- design/dgc_pkg.sv ----
package dgc_pkg;

  // Serial frame: 2 operation bits, 6 address bits, 16 data bits, MSB first
  localparam int FRAME_BITS = 24;
  localparam logic [4:0] FRAME_LEN = 5'h18;
  localparam logic [4:0] FRAME_OVERRUN = 5'h19;
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_READ = 2'h1;
  localparam logic [5:0] ADDR_GROUPING = 6'h03;

  // Field positions inside the 16-bit data word
  localparam int FLD_RESERVED_MSB = 15;
  localparam int FLD_RESERVED_LSB = 8;
  localparam int FLD_CFG_MSB = 7;
  localparam int FLD_CFG_LSB = 1;
  localparam int FLD_PARITY = 0;

  // Braking duration code that selects indefinite braking
  localparam logic [1:0] BRAKE_INDEFINITE = 2'h3;

  localparam logic [7:0] RESERVED_READ = 8'h00;
  localparam logic [7:0] STATUS_READ = 8'h00;

  // Stored configuration, bits 7 down to 1 of the register
  typedef struct packed {
    logic global_fault_pin_enable;
    logic thermal_scope_select;
    logic pump_dither_disable;
    logic second_group_add_out6;
    logic second_group_add_out5;
    logic first_group_add_out3;
    logic first_group_add_out2;
  } dgc_cfg_t;

  localparam logic [6:0] CFG_RESET = 7'h00;

  typedef struct packed {
    logic [1:0] op;
    logic [5:0] addr;
    logic [15:0] data;
  } dgc_frame_t;

  // Per-bridge regulation setting from the current/PWM registers
  typedef struct packed {
    logic regulation_mode_select;
    logic [3:0] level_setting_field;
  } dgc_bridge_set_t;

  typedef struct packed {
    logic charge_pump;
    logic [1:0] external_bridge_output;
    logic [5:0] internal_bridge_output;
  } dgc_shutdown_t;

  localparam logic [8:0] SHUTDOWN_RESET = 9'h000;

  typedef enum logic [1:0] {
    APPLY_IDLE = 2'b00,
    APPLY_WAIT_TIMED = 2'b01,
    APPLY_WAIT_INDEF = 2'b11
  } dgc_apply_t;

endpackage : dgc_pkg

// ---- verif/dgc_chk.sv ----
`timescale 1ns/1ps
module dgc_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Block inputs
  input wire logic timed_actuation_active,
  input wire logic indefinite_braking_active,
  input wire logic [1:0] braking_duration_sel,
  input wire logic [5:0][1:0] bridge_cmd,
  input wire dgc_pkg::dgc_bridge_set_t [5:0] bridge_setting,
  input wire logic [5:0] thermal_shutdown,
  input wire logic global_fault_summary_bit,
  // Block outputs
  input wire dgc_pkg::dgc_cfg_t active_cfg,
  input wire logic [5:0][1:0] bridge_drive,
  input wire logic [5:0][3:0] bridge_level,
  input wire logic [1:0][5:0] group_current_sum,
  input wire logic pump_dither_run,
  input wire dgc_pkg::dgc_shutdown_t shutdown,
  input wire logic fault_pin_out,
  input wire logic fault_pin_oe
);
  wire logic [5:0] sum_two = {2'h0, bridge_setting[3].level_setting_field}
    + {2'h0, bridge_setting[4].level_setting_field} + {2'h0, bridge_setting[5].level_setting_field};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Derived outputs lag one cycle, so skip the edge right after reset
  sequence settled;
    !$past(sys_rst);
  endsequence
  sequence timed_run;
    (timed_actuation_active && !indefinite_braking_active
      && braking_duration_sel != dgc_pkg::BRAKE_INDEFINITE) [*3];
  endsequence
  busy_hold_a: assert property (timed_run |-> $stable(active_cfg))
    else $error("config moved during timed actuation");
  dither_run_a: assert property (settled |->
    pump_dither_run == !$past(active_cfg.pump_dither_disable)) else $error("dither wrong");
  fault_enable_a: assert property (settled |->
    fault_pin_oe == $past(active_cfg.global_fault_pin_enable)) else $error("fault oe wrong");
  fault_level_a: assert property (settled |->
    fault_pin_out == !$past(global_fault_summary_bit)) else $error("fault level wrong");
  group_drive_a: assert property (settled ##0 $past(active_cfg.first_group_add_out3) |->
    bridge_drive[2] == $past(bridge_cmd[0])) else $error("member not following master");
  solo_drive_a: assert property (settled ##0 !$past(active_cfg.second_group_add_out5) |->
    bridge_drive[4] == $past(bridge_cmd[4])) else $error("solo output not own");
  master_level_a: assert property (settled ##0 $past(active_cfg.first_group_add_out2
    && bridge_setting[0].regulation_mode_select) |->
    bridge_level[1] == $past(bridge_setting[0].level_setting_field)) else $error("duty wrong");
  current_sum_a: assert property (settled ##0 $past(active_cfg.second_group_add_out5
    && active_cfg.second_group_add_out6 && !bridge_setting[3].regulation_mode_select) |->
    group_current_sum[1] == $past(sum_two)) else $error("group sum wrong");
  thermal_all_a: assert property (settled ##0
    $past(active_cfg.thermal_scope_select && |thermal_shutdown) |-> shutdown == 9'h1FF)
    else $error("global shutdown incomplete");
  thermal_one_a: assert property (settled ##0 !$past(active_cfg.thermal_scope_select) |->
    shutdown == {3'h0, $past(thermal_shutdown)}) else $error("local shutdown wrong");
endmodule : dgc_chk

// ---- verif/dgc_spi_host.sv ----
`timescale 1ns/1ps
module dgc_spi_host (
  // Serial lines
  output logic serial_clk,
  output logic chip_select_n,
  output logic serial_data_in,
  input wire logic serial_data_out
);
  initial begin
    serial_clk = 1'b0;
    chip_select_n = 1'b1;
    serial_data_in = 1'b0;
  end
  // 32 ns period, clock stands low outside frames
  task automatic xfer(input logic [23:0] f, output logic [23:0] rx);
    chip_select_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      serial_data_in = f[i];
      #16 serial_clk = 1'b1;
      rx[i] = serial_data_out;
      #16 serial_clk = 1'b0;
    end
    #20 chip_select_n = 1'b1;
    // Released line shows the inverse so a stale bit cannot pass
    serial_data_in = ~f[0];
    #60;
  endtask : xfer
endmodule : dgc_spi_host

// ---- verif/test_driver_group_config_register.sv ----
`timescale 1ns/1ps
module test_driver_group_config_register;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic serial_clk, chip_select_n, serial_data_in, serial_data_out, serial_data_oe;
  logic output_enable_pin = 1'b0;
  logic timed_actuation_active = 1'b0;
  logic indefinite_braking_active = 1'b0;
  logic [1:0] braking_duration_sel = 2'h0;
  logic reg01_write_strobe = 1'b0;
  logic [5:0][1:0] bridge_cmd = {2'h1, 2'h2, 2'h3, 2'h0, 2'h1, 2'h2};
  // Group 1 all PWM, group 2 all current mode
  dgc_pkg::dgc_bridge_set_t [5:0] bridge_setting = 30'h0440_EEB3;
  logic [5:0] thermal_shutdown = 6'h00;
  logic global_fault_summary_bit = 1'b0;
  dgc_pkg::dgc_cfg_t active_cfg;
  logic [5:0][1:0] bridge_drive;
  logic [5:0] bridge_pwm_mode;
  logic [5:0][3:0] bridge_level;
  logic [1:0][5:0] group_current_sum;
  logic pump_dither_run, fault_pin_out, fault_pin_oe;
  dgc_pkg::dgc_shutdown_t shutdown;
  int fail_count = 0;
  int n_compared = 0;
  always #5 core_clk = ~core_clk;
  dgc_grouping_reg i_dgc_grouping_reg (.core_clk, .sys_rst, .serial_clk, .chip_select_n,
    .serial_data_in, .serial_data_out, .serial_data_oe, .output_enable_pin,
    .timed_actuation_active, .indefinite_braking_active, .braking_duration_sel,
    .reg01_write_strobe, .bridge_cmd, .bridge_setting, .thermal_shutdown,
    .global_fault_summary_bit, .active_cfg, .bridge_drive, .bridge_pwm_mode, .bridge_level,
    .group_current_sum, .pump_dither_run, .shutdown, .fault_pin_out, .fault_pin_oe);
  dgc_spi_host i_dgc_spi_host (.serial_clk, .chip_select_n, .serial_data_in, .serial_data_out);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic ticks(input int n);
    repeat (n) @(negedge core_clk);
  endtask : ticks
  function automatic logic [23:0] frm(input logic [1:0] op, input logic [5:0] a,
      input logic [15:0] d);
    return {op, a, d[15:1], ~^{op, a, d[15:1]}};
  endfunction : frm
  // Reserved byte written as A5 must never read back
  task automatic wr(input logic [5:0] a, input logic [6:0] c);
    logic [23:0] rx;
    i_dgc_spi_host.xfer(frm(dgc_pkg::OP_WRITE, a, {8'hA5, c, 1'b0}), rx);
    ticks(8);
  endtask : wr
  task automatic rd(input logic [6:0] c);
    logic [23:0] rx;
    i_dgc_spi_host.xfer(frm(dgc_pkg::OP_READ, dgc_pkg::ADDR_GROUPING, 16'h0000), rx);
    chk(rx[15:0] & 16'hFFFE, {8'h00, c, 1'b0});
    ticks(2);
  endtask : rd
  task automatic cfg_is(input logic [6:0] c);
    chk({9'h000, active_cfg}, {9'h000, c});
  endtask : cfg_is
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  initial begin
    ticks(2);
    sys_rst = 1'b0;
    ticks(4);
    cfg_is(7'h00);
    rd(7'h00);
    wr(dgc_pkg::ADDR_GROUPING, 7'h7F);
    cfg_is(7'h7F);
    rd(7'h7F);
    chk({bridge_drive[2], bridge_drive[5], bridge_level[1], 2'h0, group_current_sum[1]},
      {2'h2, 2'h3, 4'h3, 2'h0, 6'h07});
    chk({14'h0, pump_dither_run, fault_pin_oe}, 16'h0001);
    thermal_shutdown = 6'h04;
    global_fault_summary_bit = 1'b1;
    ticks(2);
    chk({6'h0, fault_pin_out, shutdown}, 16'h01FF);
    thermal_shutdown = 6'h00;
    global_fault_summary_bit = 1'b0;
    ticks(2);
    chk({6'h0, fault_pin_out, shutdown}, 16'h0200);
    cfg_is(7'h7F);
    wr(dgc_pkg::ADDR_GROUPING, 7'h00);
    thermal_shutdown = 6'h04;
    ticks(2);
    chk({1'b0, bridge_drive[1], bridge_drive[4], fault_pin_oe, pump_dither_run, shutdown},
      {1'b0, 2'h1, 2'h2, 1'b0, 1'b1, 9'h004});
    thermal_shutdown = 6'h00;
    wr(6'h04, 7'h7F);
    cfg_is(7'h00);
    timed_actuation_active = 1'b1;
    wr(dgc_pkg::ADDR_GROUPING, 7'h01);
    cfg_is(7'h00);
    rd(7'h01);
    timed_actuation_active = 1'b0;
    ticks(3);
    cfg_is(7'h01);
    timed_actuation_active = 1'b1;
    ticks(20);
    timed_actuation_active = 1'b0;
    ticks(3);
    cfg_is(7'h01);
    braking_duration_sel = dgc_pkg::BRAKE_INDEFINITE;
    indefinite_braking_active = 1'b1;
    wr(dgc_pkg::ADDR_GROUPING, 7'h02);
    cfg_is(7'h01);
    reg01_write_strobe = 1'b1;
    ticks(1);
    reg01_write_strobe = 1'b0;
    ticks(2);
    cfg_is(7'h02);
    indefinite_braking_active = 1'b0;
    timed_actuation_active = 1'b1;
    wr(dgc_pkg::ADDR_GROUPING, 7'h04);
    timed_actuation_active = 1'b0;
    ticks(4);
    cfg_is(7'h02);
    output_enable_pin = 1'b1;
    ticks(6);
    cfg_is(7'h04);
    tally_and_finish;
  end
  // Whole run needs about 9 us
  initial begin
    #100000;
    fail_count++;
    tally_and_finish;
  end
endmodule : test_driver_group_config_register
bind dgc_grouping_reg dgc_chk i_dgc_chk (.core_clk, .sys_rst, .timed_actuation_active,
  .indefinite_braking_active, .braking_duration_sel, .bridge_cmd, .bridge_setting,
  .thermal_shutdown, .global_fault_summary_bit, .active_cfg, .bridge_drive, .bridge_level,
  .group_current_sum, .pump_dither_run, .shutdown, .fault_pin_out, .fault_pin_oe);
